/* File: design/cecr_top.sv */
// cluster extended control register with decoded control outputs
`timescale 1ns/100ps
`default_nettype none
`include "cecr_defines.svh"
module cecr_top
	import cecr_pkg::*;
#(
	parameter logic BUILD_READ_LATENCY_PARAM = 1'b0,
	parameter logic [1:0] BUILD_WRITE_LATENCY_PARAM = 2'b00,
	parameter logic DIRECT_CONNECT = 1'b0,
	parameter logic AXI_BUILD = 1'b0
)
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// system register access
	input wire logic acc_valid,
	input wire logic acc_write,
	input wire cecr_el_t acc_el,
	input wire logic [63:0] acc_wdata,
	output logic acc_done_q,
	output logic [63:0] acc_rdata_q,
	output cecr_result_t acc_result_q,
	output logic [5:0] acc_syndrome_q,
	// privilege state
	input wire logic el2_enabled,
	input wire logic impl_register_trap_ctl,
	input wire logic el2_ext_control_write_enable,
	input wire logic el3_ext_control_write_enable,
	input wire logic halted,
	input wire logic secure_debug_disable,
	input wire logic el3_sdd_priority,
	// cluster events
	input wire logic broadcast_atomic_pin,
	input wire logic clean_evict_unique,
	input wire logic clean_evict_shared,
	input wire logic clean_evict_flush,
	input wire logic main_poison_event,
	input wire logic periph_poison_event,
	// decoded controls
	output cecr_clean_t clean_action_q,
	output logic endpoint_order_ack_q,
	output logic request_order_ack_q,
	output logic request_order_allow_q,
	output logic [1:0] l3_read_cycles_q,
	output logic [1:0] l3_write_latency_q,
	output logic [7:0] prefetch_wait_q,
	output logic atomics_to_interconnect_q,
	output logic [1:0] stash_mode_q,
	output logic cluster_error_irq_n
);
	////////////////////////////////////////////////////////////////
	// build parameter checks
	if (BUILD_WRITE_LATENCY_PARAM == 2'b11) begin : g_bad_write_code
		$error("write latency code 11 is reserved");
	end
	// code 10 only works with the long read latency
	if (BUILD_WRITE_LATENCY_PARAM == 2'b10 && !BUILD_READ_LATENCY_PARAM) begin : g_bad_pair
		$error("write latency code 10 needs three cycle reads");
	end
	////////////////////////////////////////////////////////////////
	// reset release
	logic rst_meta_q;
	logic rst_sync_q;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end
	////////////////////////////////////////////////////////////////
	// pin synchroniser
	logic [5:0] pin_meta_q;
	logic [5:0] pin_sync_q;
	always_ff @(posedge clock or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			pin_meta_q <= 6'h00;
			pin_sync_q <= 6'h00;
		end else begin
			pin_meta_q <= {broadcast_atomic_pin, clean_evict_unique, clean_evict_shared,
				clean_evict_flush, main_poison_event, periph_poison_event};
			pin_sync_q <= pin_meta_q;
		end
	end
	logic bcast_s;
	logic ev_uc_s;
	logic ev_sc_s;
	logic ev_fl_s;
	logic pois_m_s;
	logic pois_p_s;
	assign {bcast_s, ev_uc_s, ev_sc_s, ev_fl_s, pois_m_s, pois_p_s} = pin_sync_q;
	////////////////////////////////////////////////////////////////
	// result decoding
	function automatic logic result_ok(cecr_result_t r);
		return r == CECR_OK;
	endfunction : result_ok
	function automatic logic result_traps(cecr_result_t r);
		return (r == CECR_TRAP_EL2) || (r == CECR_TRAP_EL3);
	endfunction : result_traps
	////////////////////////////////////////////////////////////////
	// access decision
	cecr_result_t chk_result;
	cecr_access_check u_check (
		.el(acc_el),
		.is_write(acc_write),
		.el2_enabled(el2_enabled),
		.impl_register_trap_ctl(impl_register_trap_ctl),
		.el2_ext_control_write_enable(el2_ext_control_write_enable),
		.el3_ext_control_write_enable(el3_ext_control_write_enable),
		.halted(halted),
		.secure_debug_disable(secure_debug_disable),
		.el3_sdd_priority(el3_sdd_priority),
		.result(chk_result)
	);
	logic wr_ok;
	assign wr_ok = acc_valid && acc_write && result_ok(chk_result);
	////////////////////////////////////////////////////////////////
	// register fields
	logic [1:0] downstream_cache_sel_q;
	logic eviction_flush_sel_q;
	logic snoop_filter_present_q;
	logic endpoint_order_ack_sel_q;
	logic request_order_ack_sel_q;
	logic request_order_allow_sel_q;
	logic l3_read_latency_sel_q;
	logic [1:0] l3_write_latency_sel_q;
	logic [2:0] prefetch_match_delay_q;
	logic atomics_keep_internal_q;
	logic [1:0] stash_without_l3_sel_q;
	logic main_port_poison_ok_q;
	logic periph_port_poison_ok_q;
	always_ff @(posedge clock or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			downstream_cache_sel_q <= `CECR_RST_DCC;
			eviction_flush_sel_q <= `CECR_RST_EFC;
			snoop_filter_present_q <= `CECR_RST_SFP;
			endpoint_order_ack_sel_q <= `CECR_RST_EOACK;
			request_order_ack_sel_q <= `CECR_RST_ROACK;
			request_order_allow_sel_q <= `CECR_RST_REQORD;
			l3_read_latency_sel_q <= BUILD_READ_LATENCY_PARAM;
			l3_write_latency_sel_q <= BUILD_WRITE_LATENCY_PARAM;
			prefetch_match_delay_q <= `CECR_RST_PFM;
			atomics_keep_internal_q <= `CECR_RST_ATOM;
			stash_without_l3_sel_q <= `CECR_RST_STASH;
			main_port_poison_ok_q <= `CECR_RST_POIS;
			periph_port_poison_ok_q <= `CECR_RST_POISPP;
		end else if (wr_ok) begin
			downstream_cache_sel_q <= acc_wdata[`CECR_DCC_HI:`CECR_DCC_LO];
			eviction_flush_sel_q <= acc_wdata[`CECR_EFC_BIT];
			snoop_filter_present_q <= acc_wdata[`CECR_SFP_BIT];
			endpoint_order_ack_sel_q <= acc_wdata[`CECR_EOACK_BIT];
			request_order_ack_sel_q <= acc_wdata[`CECR_ROACK_BIT];
			request_order_allow_sel_q <= acc_wdata[`CECR_REQORD_BIT];
			l3_read_latency_sel_q <= acc_wdata[`CECR_RDLAT_BIT];
			l3_write_latency_sel_q <= acc_wdata[`CECR_WRLAT_HI:`CECR_WRLAT_LO];
			prefetch_match_delay_q <= acc_wdata[`CECR_PFM_HI:`CECR_PFM_LO];
			atomics_keep_internal_q <= acc_wdata[`CECR_ATOM_BIT];
			stash_without_l3_sel_q <= acc_wdata[`CECR_STASH_HI:`CECR_STASH_LO];
			main_port_poison_ok_q <= acc_wdata[`CECR_POIS_BIT];
			periph_port_poison_ok_q <= acc_wdata[`CECR_POISPP_BIT];
		end
	end
	////////////////////////////////////////////////////////////////
	// read image
	logic [63:0] image;
	always_comb begin
		image = 64'h0;
		image[`CECR_DCC_HI:`CECR_DCC_LO] = downstream_cache_sel_q;
		image[`CECR_EFC_BIT] = eviction_flush_sel_q;
		image[`CECR_SFP_BIT] = snoop_filter_present_q;
		image[`CECR_EOACK_BIT] = endpoint_order_ack_sel_q;
		image[`CECR_ROACK_BIT] = request_order_ack_sel_q;
		image[`CECR_REQORD_BIT] = request_order_allow_sel_q;
		image[`CECR_RDLAT_BIT] = l3_read_latency_sel_q;
		image[`CECR_WRLAT_HI:`CECR_WRLAT_LO] = l3_write_latency_sel_q;
		image[`CECR_PFM_HI:`CECR_PFM_LO] = prefetch_match_delay_q;
		image[`CECR_ATOM_BIT] = atomics_keep_internal_q;
		image[`CECR_STASH_HI:`CECR_STASH_LO] = stash_without_l3_sel_q;
		image[`CECR_POIS_BIT] = main_port_poison_ok_q;
		image[`CECR_POISPP_BIT] = periph_port_poison_ok_q;
		if (DIRECT_CONNECT) begin
			// direct connect builds read these fields as zero
			image[`CECR_EFC_BIT:`CECR_SFP_BIT] = 2'h0;
			image[`CECR_DCC_HI:`CECR_DCC_LO] = 2'h0;
			image[`CECR_RDLAT_BIT:`CECR_WRLAT_LO] = 3'h0;
			image[`CECR_PFM_HI:`CECR_STASH_LO] = 6'h00;
			image[`CECR_POIS_BIT] = 1'b0;
			image[`CECR_POISPP_BIT] = 1'b0;
		end
	end
	////////////////////////////////////////////////////////////////
	// access answer
	always_ff @(posedge clock or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			acc_done_q <= 1'b0;
			acc_rdata_q <= 64'h0;
			acc_result_q <= CECR_OK;
			acc_syndrome_q <= 6'h00;
		end else begin
			acc_done_q <= acc_valid;
			if (acc_valid) begin
				acc_result_q <= chk_result;
				acc_rdata_q <= (!acc_write && result_ok(chk_result)) ? image : 64'h0;
				acc_syndrome_q <= result_traps(chk_result)
					? `CECR_EC_SYSREG : 6'h00;
			end
		end
	end
	////////////////////////////////////////////////////////////////
	// decoded controls
	logic [1:0] dcc_eff;
	logic efc_eff;
	logic sfp_eff;
	assign dcc_eff = DIRECT_CONNECT ? 2'h0 : downstream_cache_sel_q;
	assign efc_eff = DIRECT_CONNECT ? 1'b0 : eviction_flush_sel_q;
	assign sfp_eff = DIRECT_CONNECT ? 1'b0 : snoop_filter_present_q;
	cecr_clean_t with_data;
	always_comb begin
		with_data = CECR_CLEAN_NONE;
		if (!ev_fl_s || efc_eff) begin
			case (dcc_eff)
				2'h1: with_data = ev_uc_s ? CECR_CLEAN_WEF : CECR_CLEAN_NONE;
				2'h2: with_data = ev_uc_s ? CECR_CLEAN_WEOE : CECR_CLEAN_NONE;
				2'h3: with_data = (ev_uc_s || ev_sc_s) ? CECR_CLEAN_WEOE : CECR_CLEAN_NONE;
				default: with_data = CECR_CLEAN_NONE;
			endcase
		end
	end
	logic any_evict;
	assign any_evict = ev_uc_s || ev_sc_s;
	always_ff @(posedge clock or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			clean_action_q <= CECR_CLEAN_NONE;
		end else if (with_data != CECR_CLEAN_NONE) begin
			clean_action_q <= with_data;
		end else begin
			clean_action_q <= (any_evict && sfp_eff) ? CECR_CLEAN_EVICT : CECR_CLEAN_NONE;
		end
	end
	always_ff @(posedge clock or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			endpoint_order_ack_q <= 1'b0;
			request_order_ack_q <= 1'b0;
			request_order_allow_q <= 1'b0;
			l3_read_cycles_q <= `CECR_RDLAT_SHORT;
			l3_write_latency_q <= 2'h0;
			prefetch_wait_q <= 8'h01;
			atomics_to_interconnect_q <= 1'b0;
			stash_mode_q <= `CECR_RST_STASH;
		end else begin
			endpoint_order_ack_q <= endpoint_order_ack_sel_q;
			request_order_ack_q <= request_order_ack_sel_q;
			request_order_allow_q <= request_order_allow_sel_q;
			l3_read_cycles_q <= (l3_read_latency_sel_q && !DIRECT_CONNECT)
				? `CECR_RDLAT_LONG : `CECR_RDLAT_SHORT;
			l3_write_latency_q <= DIRECT_CONNECT ? 2'h0 : l3_write_latency_sel_q;
			prefetch_wait_q <= DIRECT_CONNECT ? 8'h01
				: 8'(8'h01 << prefetch_match_delay_q);
			atomics_to_interconnect_q <= bcast_s && (DIRECT_CONNECT || !atomics_keep_internal_q);
			stash_mode_q <= DIRECT_CONNECT ? 2'h0 : stash_without_l3_sel_q;
		end
	end
	////////////////////////////////////////////////////////////////
	// poisoned data error interrupt
	logic pois_raise;
	assign pois_raise = !AXI_BUILD && !DIRECT_CONNECT &&
		((pois_m_s && !main_port_poison_ok_q) || (pois_p_s && !periph_port_poison_ok_q));
	always_ff @(posedge clock or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			cluster_error_irq_n <= 1'b1;
		end else begin
			cluster_error_irq_n <= !pois_raise;
		end
	end
endmodule : cecr_top
`default_nettype wire

/* File: design/cecr_defines.svh */
// constants for the cluster extended control register block
`ifndef CECR_DEFINES_SVH
`define CECR_DEFINES_SVH
`define CECR_WIDTH 64
`define CECR_DCC_HI 45
`define CECR_DCC_LO 44
`define CECR_EFC_BIT 43
`define CECR_SFP_BIT 42
`define CECR_EOACK_BIT 20
`define CECR_ROACK_BIT 19
`define CECR_REQORD_BIT 18
`define CECR_RDLAT_BIT 17
`define CECR_WRLAT_HI 16
`define CECR_WRLAT_LO 15
`define CECR_PFM_HI 10
`define CECR_PFM_LO 8
`define CECR_ATOM_BIT 7
`define CECR_STASH_HI 6
`define CECR_STASH_LO 5
`define CECR_POIS_BIT 4
`define CECR_POISPP_BIT 1
`define CECR_RST_DCC 2'h3
`define CECR_RST_EFC 1'h0
`define CECR_RST_SFP 1'h1
`define CECR_RST_EOACK 1'h0
`define CECR_RST_ROACK 1'h0
`define CECR_RST_REQORD 1'h0
`define CECR_RST_PFM 3'h5
`define CECR_RST_ATOM 1'h0
`define CECR_RST_STASH 2'h2
`define CECR_RST_POIS 1'h1
`define CECR_RST_POISPP 1'h1
`define CECR_EC_SYSREG 6'h18
`define CECR_RDLAT_SHORT 2'h2
`define CECR_RDLAT_LONG 2'h3
`endif

/* File: design/cecr_pkg.sv */
// types for the cluster extended control register block
package cecr_pkg;
	typedef enum logic [1:0] {
		CECR_EL0,
		CECR_EL1,
		CECR_EL2,
		CECR_EL3
	} cecr_el_t;
	typedef enum logic [1:0] {
		CECR_OK,
		CECR_UNDEF,
		CECR_TRAP_EL2,
		CECR_TRAP_EL3
	} cecr_result_t;
	typedef enum logic [1:0] {
		CECR_CLEAN_NONE,
		CECR_CLEAN_EVICT,
		CECR_CLEAN_WEF,
		CECR_CLEAN_WEOE
	} cecr_clean_t;
endpackage : cecr_pkg

/* File: design/cecr_access_check.sv */
// privilege and trap decision for one register access
`timescale 1ns/100ps
`default_nettype none
module cecr_access_check
	import cecr_pkg::*;
(
	// access
	input wire cecr_el_t el,
	input wire logic is_write,
	// system state
	input wire logic el2_enabled,
	input wire logic impl_register_trap_ctl,
	input wire logic el2_ext_control_write_enable,
	input wire logic el3_ext_control_write_enable,
	input wire logic halted,
	input wire logic secure_debug_disable,
	input wire logic el3_sdd_priority,
	// decision
	output cecr_result_t result
);
	logic undef_sdd;
	assign undef_sdd = halted && secure_debug_disable;
	always_comb begin
		result = CECR_OK;
		case (el)
			CECR_EL0: result = CECR_UNDEF;
			CECR_EL1: begin
				if (el2_enabled && impl_register_trap_ctl) begin
					result = CECR_TRAP_EL2;
				end else if (is_write) begin
					if (undef_sdd && el3_sdd_priority && !el3_ext_control_write_enable) begin
						result = CECR_UNDEF;
					end else if (el2_enabled && !el2_ext_control_write_enable) begin
						result = CECR_TRAP_EL2;
					end else if (!el3_ext_control_write_enable) begin
						result = undef_sdd ? CECR_UNDEF : CECR_TRAP_EL3;
					end
				end
			end
			CECR_EL2: begin
				if (is_write && !el3_ext_control_write_enable) begin
					result = undef_sdd ? CECR_UNDEF : CECR_TRAP_EL3;
				end
			end
			default: result = CECR_OK;
		endcase
	end
endmodule : cecr_access_check
`default_nettype wire

/* File: verification/cecr_top_props.sv */
// concurrent checks on the extended control register ports
`timescale 1ns/100ps
`default_nettype none
module cecr_top_props
	import cecr_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// access
	input wire logic acc_valid,
	input wire logic acc_write,
	input wire cecr_el_t acc_el,
	input wire logic acc_done_q,
	input wire logic [63:0] acc_rdata_q,
	input wire cecr_result_t acc_result_q,
	input wire logic [5:0] acc_syndrome_q,
	// privilege and controls
	input wire logic el2_enabled,
	input wire logic impl_register_trap_ctl,
	input wire logic request_order_allow_q,
	input wire logic [7:0] prefetch_wait_q
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	localparam logic [63:0] RSV = 64'hFFFF_C3FF_FFE0_780D;
	////////////////////////////////////////
	done_next_a: assert property (acc_valid |=> acc_done_q)
		else $error("no done after access");
	el0_undef_a: assert property (acc_valid && acc_el == CECR_EL0 |=> acc_result_q == CECR_UNDEF)
		else $error("lowest level not refused");
	el1_trap_a: assert property (acc_valid && acc_el == CECR_EL1 && el2_enabled
		&& impl_register_trap_ctl |=> acc_result_q == CECR_TRAP_EL2 && acc_syndrome_q == 6'h18)
		else $error("trap to level two missing");
	el3_ok_a: assert property (acc_valid && acc_el == CECR_EL3 |=> acc_result_q == CECR_OK)
		else $error("top level refused");
	syndrome_class_a: assert property (acc_done_q |-> (acc_syndrome_q == 6'h18) ==
		(acc_result_q inside {CECR_TRAP_EL2, CECR_TRAP_EL3}))
		else $error("syndrome wrong");
	refused_zero_a: assert property (acc_done_q && ($past(acc_write) || acc_result_q != CECR_OK)
		|-> acc_rdata_q == 64'h0)
		else $error("read data not zero");
	reserved_zero_a: assert property (acc_done_q |-> (acc_rdata_q & RSV) == 64'h0)
		else $error("reserved bits set");
	order_follow_a: assert property ($changed(request_order_allow_q) |->
		$past(acc_valid && acc_write, 2))
		else $error("order control moved alone");
	prefetch_power_a: assert property ($onehot(prefetch_wait_q))
		else $error("prefetch wait not a power of two");
	cover property (acc_valid && acc_write && acc_el == CECR_EL3);
	cover property (acc_done_q && acc_result_q == CECR_TRAP_EL3);
	cover property ($rose(request_order_allow_q));
endmodule : cecr_top_props
bind cecr_top cecr_top_props i_cecr_top_props (.clock, .rst_n, .acc_valid, .acc_write,
	.acc_el, .acc_done_q, .acc_rdata_q, .acc_result_q, .acc_syndrome_q, .el2_enabled,
	.impl_register_trap_ctl, .request_order_allow_q, .prefetch_wait_q);
`default_nettype wire

/* File: verification/cecr_far_side.sv */
// interconnect side event source for evictions, poison and atomics
`timescale 1ns/100ps
`default_nettype none
module cecr_far_side (
	// clock
	input wire logic clock,
	// wanted levels
	input wire logic [5:0] ev_want,
	// event pins
	output logic broadcast_atomic_pin,
	output logic clean_evict_unique,
	output logic clean_evict_shared,
	output logic clean_evict_flush,
	output logic main_poison_event,
	output logic periph_poison_event
);
	// levels move off the sampling edge and hold until changed
	always_ff @(negedge clock) begin
		{periph_poison_event, main_poison_event, clean_evict_flush} <= ev_want[5:3];
		{clean_evict_shared, clean_evict_unique, broadcast_atomic_pin} <= ev_want[2:0];
	end
endmodule : cecr_far_side
`default_nettype wire

/* File: verification/cecr_top_tb.sv */
// self-checking bench for the extended control register
`timescale 1ns/100ps
`default_nettype none
module cecr_top_tb;
	import cecr_pkg::*;
	localparam logic [63:0] WMASK = 64'h0000_3C00_001F_87F2;
	localparam logic [63:0] RST_IMG = 64'h0000_3400_0003_0552;
	localparam logic [63:0] DC_MASK = 64'h0000_0000_001C_0000;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic acc_valid = 1'b0;
	logic acc_write = 1'b0;
	cecr_el_t acc_el = CECR_EL3;
	logic [63:0] acc_wdata = 64'h0;
	logic el2_enabled = 1'b0;
	logic impl_register_trap_ctl = 1'b0;
	logic el2_ext_control_write_enable = 1'b1;
	logic el3_ext_control_write_enable = 1'b1;
	logic halted = 1'b0;
	logic secure_debug_disable = 1'b0;
	logic el3_sdd_priority = 1'b0;
	logic [5:0] ev_want = 6'h0;
	logic broadcast_atomic_pin, clean_evict_unique, clean_evict_shared, clean_evict_flush;
	logic main_poison_event, periph_poison_event, acc_done_q, endpoint_order_ack_q;
	logic request_order_ack_q, request_order_allow_q, atomics_to_interconnect_q;
	logic cluster_error_irq_n;
	logic [63:0] acc_rdata_q, img, d;
	cecr_result_t acc_result_q;
	cecr_clean_t clean_action_q;
	logic [5:0] acc_syndrome_q;
	logic [1:0] l3_read_cycles_q, l3_write_latency_q, stash_mode_q;
	logic [7:0] prefetch_wait_q;
	logic [63:0] dc_rdata;
	cecr_clean_t dc_clean;
	logic dc_irq_n, dc_atom;
	logic [1:0] dc_rdcyc, dc_wrlat, dc_stash;
	logic [7:0] dc_pfw;
	int mismatches = 0;
	int comparisons = 0;
	int seed = 32'hF3F9116B;
	cecr_top #(.BUILD_READ_LATENCY_PARAM(1'b1), .BUILD_WRITE_LATENCY_PARAM(2'h2)) i_cecr_top (
		.clock, .rst_n, .acc_valid, .acc_write, .acc_el, .acc_wdata, .acc_done_q, .acc_rdata_q,
		.acc_result_q, .acc_syndrome_q, .el2_enabled, .impl_register_trap_ctl,
		.el2_ext_control_write_enable, .el3_ext_control_write_enable, .halted,
		.secure_debug_disable, .el3_sdd_priority, .broadcast_atomic_pin, .clean_evict_unique,
		.clean_evict_shared, .clean_evict_flush, .main_poison_event, .periph_poison_event,
		.clean_action_q, .endpoint_order_ack_q, .request_order_ack_q, .request_order_allow_q,
		.l3_read_cycles_q, .l3_write_latency_q, .prefetch_wait_q, .atomics_to_interconnect_q,
		.stash_mode_q, .cluster_error_irq_n);
	// direct connect, interface without poisoning: gated fields read and act as zero
	cecr_top #(.DIRECT_CONNECT(1'b1), .AXI_BUILD(1'b1)) i_cecr_top_dc (
		.clock, .rst_n, .acc_valid, .acc_write, .acc_el, .acc_wdata, .acc_done_q(),
		.acc_rdata_q(dc_rdata), .acc_result_q(), .acc_syndrome_q(), .el2_enabled,
		.impl_register_trap_ctl, .el2_ext_control_write_enable, .el3_ext_control_write_enable,
		.halted, .secure_debug_disable, .el3_sdd_priority, .broadcast_atomic_pin,
		.clean_evict_unique, .clean_evict_shared, .clean_evict_flush, .main_poison_event,
		.periph_poison_event, .clean_action_q(dc_clean), .endpoint_order_ack_q(),
		.request_order_ack_q(), .request_order_allow_q(), .l3_read_cycles_q(dc_rdcyc),
		.l3_write_latency_q(dc_wrlat), .prefetch_wait_q(dc_pfw),
		.atomics_to_interconnect_q(dc_atom), .stash_mode_q(dc_stash),
		.cluster_error_irq_n(dc_irq_n));
	cecr_far_side i_cecr_far_side (.clock, .ev_want, .broadcast_atomic_pin, .clean_evict_unique,
		.clean_evict_shared, .clean_evict_flush, .main_poison_event, .periph_poison_event);
	initial begin
		forever #5 clock = ~clock;
	end
	////////////////////////////////////////
	task automatic chk(logic [63:0] g, logic [63:0] e, string m);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("Error %0t %s got %h want %h", $time, m, g, e);
		end
	endtask : chk
	function automatic cecr_result_t er(logic w, cecr_el_t el);
		logic hs;
		hs = halted && secure_debug_disable;
		if (el == CECR_EL0) return CECR_UNDEF;
		if (el == CECR_EL1 && el2_enabled && impl_register_trap_ctl) return CECR_TRAP_EL2;
		if (!w || el == CECR_EL3) return CECR_OK;
		if (hs && el3_sdd_priority && !el3_ext_control_write_enable) return CECR_UNDEF;
		if (el == CECR_EL1 && el2_enabled && !el2_ext_control_write_enable) return CECR_TRAP_EL2;
		if (!el3_ext_control_write_enable) return hs ? CECR_UNDEF : CECR_TRAP_EL3;
		return CECR_OK;
	endfunction : er
	function automatic cecr_clean_t ec(logic [63:0] r, logic [5:0] e);
		logic [1:0] c;
		c = (e[3] && !r[43]) ? 2'h0 : r[45:44];
		if (e[1] && c != 2'h0) return (c == 2'h1) ? CECR_CLEAN_WEF : CECR_CLEAN_WEOE;
		if (e[2] && c == 2'h3) return CECR_CLEAN_WEOE;
		return ((e[1] || e[2]) && r[42]) ? CECR_CLEAN_EVICT : CECR_CLEAN_NONE;
	endfunction : ec
	// keeps software off the reserved write code and off code 2 with short reads
	function automatic logic [63:0] fix(logic [63:0] v);
		if (v[16:15] == 2'h3) v[16] = 1'b0;
		if (v[16:15] == 2'h2) v[17] = 1'b1;
		return v;
	endfunction : fix
	// entered at a falling edge; back-to-back calls keep acc_valid high
	task automatic acc(logic w, cecr_el_t el, logic [63:0] v);
		cecr_result_t r;
		r = er(w, el);
		acc_valid = 1'b1;
		acc_write = w;
		acc_el = el;
		acc_wdata = v;
		@(negedge clock);
		chk(acc_done_q, 64'h1, "done");
		chk(acc_result_q, r, "result");
		chk(acc_syndrome_q, (r == CECR_TRAP_EL2 || r == CECR_TRAP_EL3) ? 6'h18 : 6'h0, "syn");
		chk(acc_rdata_q, (!w && r == CECR_OK) ? img : 64'h0, "rdata");
		chk(dc_rdata, (!w && r == CECR_OK) ? img & DC_MASK : 64'h0, "dc rdata");
		if (w && r == CECR_OK) img = v & WMASK;
	endtask : acc
	task automatic ctl;
		repeat (5) @(negedge clock);
		chk(clean_action_q, ec(img, ev_want), "clean");
		chk({endpoint_order_ack_q, request_order_ack_q, request_order_allow_q}, img[20:18],
			"order");
		chk(l3_read_cycles_q, img[17] ? 2'h3 : 2'h2, "rdlat");
		chk(l3_write_latency_q, img[16:15], "wrlat");
		chk(prefetch_wait_q, 8'h1 << img[10:8], "prefetch");
		chk({atomics_to_interconnect_q, stash_mode_q}, {ev_want[0] & ~img[7], img[6:5]},
			"atom");
		chk(cluster_error_irq_n, !(ev_want[4] && !img[4] || ev_want[5] && !img[1]), "irq");
		chk({dc_clean, dc_irq_n, dc_rdcyc, dc_wrlat, dc_stash, dc_pfw, dc_atom},
			{CECR_CLEAN_NONE, 1'b1, 2'h2, 2'h0, 2'h0, 8'h01, ev_want[0]}, "dc ctl");
	endtask : ctl
	task automatic do_reset;
		acc_valid = 1'b0;
		ev_want = 6'h0;
		rst_n = 1'b0;
		img = RST_IMG;
		repeat (12) @(negedge clock);
		rst_n = 1'b1;
		repeat (4) @(negedge clock);
		acc(1'b0, CECR_EL3, 64'h0);
		acc_valid = 1'b0;
		ctl();
	endtask : do_reset
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish
	////////////////////////////////////////
	initial begin
		do_reset();
		repeat (300) begin
			{el2_enabled, impl_register_trap_ctl, el2_ext_control_write_enable,
				el3_ext_control_write_enable, halted, secure_debug_disable,
				el3_sdd_priority} = 7'($random(seed));
			d = fix({$random(seed), $random(seed)});
			acc(1'($random(seed)), cecr_el_t'(2'($random(seed))), d);
		end
		for (int k = 0; k < 64; k++) begin
			d = fix({$random(seed), $random(seed)});
			d[45:42] = k[5:2];
			acc(1'b1, CECR_EL3, d);
			acc(1'b0, CECR_EL3, 64'h0);
			acc_valid = 1'b0;
			ev_want = {2'($random(seed)), k[1], k[0], ~k[0], 1'($random(seed))};
			ctl();
		end
		do_reset();
		tally_and_finish();
	end
	// about 800 cycles are expected
	initial begin
		repeat (5000) @(posedge clock);
		mismatches++;
		tally_and_finish();
	end
endmodule : cecr_top_tb
`default_nettype wire
